// >>> design/bmh_handler.sv
// Message handler that decodes host requests, builds each answer whole and sends it byte by byte.
`timescale 1ns/10ps
// Notes on behaviour
// RULE1: host opens with ping, zero flags
// RULE2: ping target must be first/second stage
// RULE3: types are 0, 1, 2
// RULE4: ping answer pass=1 type, fail=0 error
// RULE5: only eight standard rates accepted
// RULE6: host may skip rate change
// RULE7: no rate change over USB/Ethernet/second port
// RULE8: rate answer address 0 or error
// RULE9: answer fully sent before rate switch
// RULE10: host waits 10-100 ms after answer
// RULE11: bounds request count 4, keep both
// RULE12: ping and rate messages count zero
// RULE13: subID codes 1 through 6
// RULE14: fail codes 0, 1, 2
// RULE15: eight-byte header then data
// RULE16: multi-byte fields least significant first
// RULE17: failed rate change keeps current rate
module bmh_handler
#(
  parameter logic [31:0] RUNNING_TYPE = bmh_pkg::SECOND_STAGE_LOADER_TYPE
)
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic tx_ready_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  output logic [31:0] baud_rate_o,
  output logic baud_change_o,
  output logic [31:0] min_addr_o,
  output logic [31:0] max_addr_o,
  output logic bounds_valid_o,
  output logic bad_message_o
);
  import bmh_pkg::*;
  typedef struct packed {
    bmh_state_t state;
    logic [63:0] hdr;
    logic [31:0] data;
    logic [3:0] cnt;
    logic [63:0] ans;
    logic [31:0] new_rate;
    logic rate_pending;
    logic [7:0] tx_data;
    logic tx_valid;
    logic [31:0] baud;
    logic baud_change;
    logic [31:0] min_addr;
    logic [31:0] max_addr;
    logic bounds_valid;
    logic bad_message;
  } bmh_regs_t;
  bmh_regs_t s_reg;
  bmh_regs_t s_next;
  logic rate_ok;
  logic [7:0] h_sub;
  logic [15:0] h_count;
  logic [31:0] h_addr;
  // Header fields arrive least significant byte first, so the shift register fills from the top.
  assign h_sub = s_reg.hdr[7:0]; // RULE15 RULE16
  // The request's pass/fail byte in bits 15:8 is not checked.
  // Hosts fill it with zero, so a stray value there does not drop the message.
  assign h_count = s_reg.hdr[31:16];
  assign h_addr = s_reg.hdr[63:32];
  bmh_rate_check u_rate_check
  (
    .rate_i(h_addr),
    .ok_o(rate_ok)
  );
  function automatic logic [63:0] build_answer(input logic [7:0] sub, input logic pass,
    input logic [31:0] addr);
    build_answer = {addr, COUNT_NONE, (pass ? RESULT_PASS : RESULT_FAIL), sub}; // RULE12
  endfunction
  always_comb
  begin
    s_next = s_reg;
    s_next.baud_change = 1'b0;
    s_next.bad_message = 1'b0;
    case (s_reg.state)
      BMH_RX:
      begin
        if (rx_valid_i)
        begin
          s_next.hdr = {rx_data_i, s_reg.hdr[63:8]};
          s_next.cnt = s_reg.cnt + 4'h1;
        end
      end
      BMH_BOUNDS:
      begin
        if (rx_valid_i)
        begin
          s_next.data = {rx_data_i, s_reg.data[31:8]}; // RULE16
          s_next.cnt = s_reg.cnt + 4'h1;
          if (s_reg.cnt == 4'(BOUNDS_DATA_BYTES - 1))
          begin
            s_next.cnt = 4'h0;
            s_next.state = BMH_DONE;
          end
        end
      end
      BMH_DONE:
      begin
        // A complete header (and data, if any) is decoded here.
        s_next.state = BMH_TX;
        s_next.cnt = 4'h0;
        if (h_sub == SUB_PING_REQUEST && h_count == COUNT_NONE) // RULE13 RULE1 RULE12
        begin
          if (h_addr == FIRST_STAGE_LOADER_TYPE || h_addr == SECOND_STAGE_LOADER_TYPE) // RULE2 RULE3
          begin
            s_next.ans = build_answer(SUB_PING_ANSWER, 1'b1, RUNNING_TYPE); // RULE4
          end
          else
          begin
            s_next.ans = build_answer(SUB_PING_ANSWER, 1'b0, BAD_PROBE_TARGET_ERROR); // RULE4 RULE14
          end
        end
        else if (h_sub == SUB_RATE_CHANGE_REQUEST && h_count == COUNT_NONE) // RULE12
        begin
          if (rate_ok)
          begin
            s_next.ans = build_answer(SUB_RATE_CHANGE_ANSWER, 1'b1, 32'h0000_0000); // RULE8
            s_next.new_rate = h_addr;
            s_next.rate_pending = 1'b1;
          end
          else
          begin
            s_next.ans = build_answer(SUB_RATE_CHANGE_ANSWER, 1'b0, BAD_RATE_ERROR); // RULE8 RULE17
          end
        end
        else if (h_sub == SUB_IMAGE_BOUNDS_REQUEST && h_count == COUNT_BOUNDS) // RULE11
        begin
          if (h_addr <= s_reg.data)
          begin
            s_next.min_addr = h_addr; // RULE11
            s_next.max_addr = s_reg.data;
            s_next.bounds_valid = 1'b1;
            s_next.ans = build_answer(SUB_IMAGE_BOUNDS_ANSWER, 1'b1, 32'h0000_0000);
          end
          else
          begin
            s_next.ans = build_answer(SUB_IMAGE_BOUNDS_ANSWER, 1'b0, BOUNDS_RANGE_ERROR); // RULE14
          end
        end
        else
        begin
          // Unknown or malformed requests are dropped without an answer.
          s_next.bad_message = 1'b1;
          s_next.state = BMH_RX;
        end
      end
      BMH_TX:
      begin
        if (!s_reg.tx_valid || tx_ready_i)
        begin
          if (s_reg.cnt == 4'(HEADER_BYTES))
          begin
            s_next.tx_valid = 1'b0;
            s_next.state = BMH_RX;
            s_next.cnt = 4'h0;
            // The answer's last byte has been taken at the old rate before the switch.
            if (s_reg.rate_pending) // RULE9
            begin
              s_next.baud = s_reg.new_rate;
              s_next.baud_change = 1'b1;
              s_next.rate_pending = 1'b0;
            end
          end
          else
          begin
            s_next.tx_data = s_reg.ans[7:0]; // RULE16
            s_next.ans = {8'h00, s_reg.ans[63:8]};
            s_next.tx_valid = 1'b1;
            s_next.cnt = s_reg.cnt + 4'h1;
          end
        end
      end
      default:
      begin
        s_next.state = BMH_RX;
      end
    endcase
    if (s_reg.state == BMH_RX && rx_valid_i && s_reg.cnt == 4'(HEADER_BYTES - 1))
    begin
      s_next.cnt = 4'h0;
      // Header is complete once the eighth byte is in; the new byte is the last.
      if (s_next.hdr[7:0] == SUB_IMAGE_BOUNDS_REQUEST && s_next.hdr[31:16] == COUNT_BOUNDS)
      begin
        s_next.state = BMH_BOUNDS; // RULE15
      end
      else
      begin
        s_next.state = BMH_DONE;
      end
    end
  end
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_reg <= '{state: BMH_RX, hdr: 64'h0, data: 32'h0, cnt: 4'h0, ans: 64'h0,
        new_rate: RESET_BAUD, rate_pending: 1'b0, tx_data: 8'h00, tx_valid: 1'b0,
        baud: RESET_BAUD, baud_change: 1'b0, min_addr: RESET_MIN_ADDR,
        max_addr: RESET_MAX_ADDR, bounds_valid: 1'b0, bad_message: 1'b0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end
  assign tx_data_o = s_reg.tx_data;
  assign tx_valid_o = s_reg.tx_valid;
  assign baud_rate_o = s_reg.baud;
  assign baud_change_o = s_reg.baud_change;
  assign min_addr_o = s_reg.min_addr;
  assign max_addr_o = s_reg.max_addr;
  assign bounds_valid_o = s_reg.bounds_valid;
  assign bad_message_o = s_reg.bad_message;
endmodule

// >>> design/bmh_pkg.sv
// Package with message codes, field layout and reset values for the bootload message handler.
package bmh_pkg;
  localparam int HEADER_BYTES = 8;
  localparam int BOUNDS_DATA_BYTES = 4;
  localparam logic [7:0] SUB_PING_REQUEST = 8'h01;
  localparam logic [7:0] SUB_PING_ANSWER = 8'h02;
  localparam logic [7:0] SUB_RATE_CHANGE_REQUEST = 8'h03;
  localparam logic [7:0] SUB_RATE_CHANGE_ANSWER = 8'h04;
  localparam logic [7:0] SUB_IMAGE_BOUNDS_REQUEST = 8'h05;
  localparam logic [7:0] SUB_IMAGE_BOUNDS_ANSWER = 8'h06;
  localparam logic [31:0] FIRST_STAGE_LOADER_TYPE = 32'h0000_0000;
  localparam logic [31:0] SECOND_STAGE_LOADER_TYPE = 32'h0000_0001;
  localparam logic [31:0] APPLICATION_PROGRAM_TYPE = 32'h0000_0002;
  localparam logic [31:0] BAD_PROBE_TARGET_ERROR = 32'h0000_0000;
  localparam logic [31:0] BAD_RATE_ERROR = 32'h0000_0001;
  localparam logic [31:0] BOUNDS_RANGE_ERROR = 32'h0000_0002;
  localparam logic [7:0] RESULT_PASS = 8'h01;
  localparam logic [7:0] RESULT_FAIL = 8'h00;
  localparam logic [15:0] COUNT_NONE = 16'h0000;
  localparam logic [15:0] COUNT_BOUNDS = 16'h0004;
  localparam logic [31:0] RESET_BAUD = 32'h0001_C200;
  localparam logic [31:0] RESET_MIN_ADDR = 32'h0000_0000;
  localparam logic [31:0] RESET_MAX_ADDR = 32'h0000_0000;
  typedef enum logic [1:0] {BMH_RX, BMH_BOUNDS, BMH_TX, BMH_DONE} bmh_state_t;
endpackage

// >>> design/bmh_rate_check.sv
// Checks a requested port rate against the supported set.
`timescale 1ns/10ps
module bmh_rate_check
(
  input wire logic [31:0] rate_i,
  output logic ok_o
);
  import bmh_pkg::*;
  localparam logic [31:0] RATES [8] = '{32'h0000_04B0, 32'h0000_0960, 32'h0000_12C0,
    32'h0000_2580, 32'h0000_4B00, 32'h0000_9600, 32'h0000_E100, 32'h0001_C200};
  logic [7:0] hit;
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_rate
      assign hit[g] = (rate_i == RATES[g]); // RULE5
    end
  endgenerate
  assign ok_o = |hit;
endmodule

// >>> verif/bmh_monitor.sv
// Concurrent checks on the ports of the bootload message handler.
`timescale 1ns/10ps
module bmh_monitor
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic rx_valid_i,
  input wire logic tx_ready_i,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_valid_o,
  input wire logic [31:0] baud_rate_o,
  input wire logic baud_change_o,
  input wire logic [31:0] min_addr_o,
  input wire logic [31:0] max_addr_o,
  input wire logic bounds_valid_o,
  input wire logic bad_message_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  a_tx_holds: assert property
    (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o)) else $error("byte moved");
  a_answer_kind: assert property
    ($rose(tx_valid_o) |-> tx_data_o inside {8'h02, 8'h04, 8'h06}) else $error("bad subid");
  a_answer_delay: assert property
    ($rose(tx_valid_o) |-> $past(rx_valid_i, 3)) else $error("answer late or early");
  a_rate_after: assert property
    (baud_change_o |-> $fell(tx_valid_o)) else $error("rate switched mid answer");
  a_rate_legal: assert property
    (baud_change_o |-> baud_rate_o inside {32'h0000_04B0, 32'h0000_0960, 32'h0000_12C0,
      32'h0000_2580, 32'h0000_4B00, 32'h0000_9600, 32'h0000_E100, 32'h0001_C200})
      else $error("illegal rate");
  a_rate_quiet: assert property
    ($changed(baud_rate_o) |-> baud_change_o) else $error("rate moved silently");
  a_bounds_order: assert property
    (bounds_valid_o |-> min_addr_o <= max_addr_o) else $error("bounds reversed");
  a_drop_silent: assert property
    (bad_message_o |-> !tx_valid_o [*3]) else $error("dropped header answered");
endmodule
bind bmh_handler bmh_monitor mon (.*);

// >>> verif/bmh_host.sv
// Host loader model that sends requests and collects eight byte answers.
`timescale 1ns/10ps
module bmh_host
(
  input wire logic clk_sys_i,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_valid_o,
  output logic [7:0] rx_data_i,
  output logic rx_valid_i,
  output logic tx_ready_i
);
  logic slow = 1'b0;
  logic [63:0] ans;
  int got;
  initial
  begin
    rx_data_i = 8'h00;
    rx_valid_i = 1'b0;
    tx_ready_i = 1'b0;
  end
  task automatic xfer(input logic [7:0] sub, input logic [15:0] cnt,
    input logic [31:0] addr, input logic [31:0] data);
    logic [95:0] v;
    v = {data, addr, cnt, 8'h00, sub};
    got = 0;
    for (int i = 0; i < ((cnt == 16'h0004) ? 12 : 8); i++)
    begin
      @(posedge clk_sys_i) #1;
      rx_data_i = v[8*i +: 8];
      rx_valid_i = 1'b1;
    end
    @(posedge clk_sys_i) #1;
    rx_valid_i = 1'b0;
    rx_data_i = ~rx_data_i;
    for (int c = 0; c < 60 && got < 8; c++)
    begin
      @(posedge clk_sys_i);
      if (tx_valid_o && tx_ready_i)
      begin
        ans[8*got +: 8] = tx_data_o;
        got++;
      end
      #1 tx_ready_i = (got < 8) && !(slow && tx_ready_i);
    end
  endtask
endmodule

// >>> verif/bmh_handler_tb.sv
// Self-checking testbench for the bootload message handler.
`timescale 1ns/10ps
module bmh_handler_tb;
  import bmh_pkg::*;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] rx_data_i, tx_data_o;
  logic rx_valid_i, tx_ready_i, tx_valid_o, baud_change_o, bounds_valid_o, bad_message_o;
  logic [31:0] baud_rate_o, min_addr_o, max_addr_o;
  int errors = 0;
  int checked = 0;
  int drops = 0;
  int switches = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (bad_message_o === 1'b1) drops++;
  always @(posedge clk_sys_i) if (baud_change_o === 1'b1) switches++;
  bmh_handler dut (.*);
  bmh_host host (.*);
  task automatic chk(input logic ok, input string what);
    checked++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  task automatic t_ping;
    host.xfer(SUB_PING_REQUEST, COUNT_NONE, SECOND_STAGE_LOADER_TYPE, 32'h0);
    chk(host.ans === {SECOND_STAGE_LOADER_TYPE, 16'h0, RESULT_PASS, SUB_PING_ANSWER}, "ping");
    host.xfer(SUB_PING_REQUEST, COUNT_NONE, FIRST_STAGE_LOADER_TYPE, 32'h0);
    chk(host.got === 8 && host.ans === {SECOND_STAGE_LOADER_TYPE, 16'h0, RESULT_PASS,
      SUB_PING_ANSWER}, "ping first stage");
    for (int t = 2; t < 4; t++)
    begin
      host.xfer(SUB_PING_REQUEST, COUNT_NONE, t, 32'h0);
      chk(host.got === 8 && host.ans === {BAD_PROBE_TARGET_ERROR, 16'h0,
        16'h0002}, "ping fail");
    end
  endtask
  task automatic t_rate;
    logic [31:0] r [9] = '{32'h0000_04B0, 32'h0000_0960, 32'h0000_12C0, 32'h0000_2580,
      32'h0000_4B00, 32'h0000_9600, 32'h0000_E100, 32'h0001_C200, 32'h0000_03E8};
    int seen;
    foreach (r[i])
    begin
      host.slow = (i % 2 == 1);
      seen = switches;
      host.xfer(SUB_RATE_CHANGE_REQUEST, COUNT_NONE, r[i], 32'h0);
      chk(host.got === 8 && host.ans === {(i < 8) ? 32'h0 : BAD_RATE_ERROR, 16'h0, (i < 8) ?
        RESULT_PASS : RESULT_FAIL, SUB_RATE_CHANGE_ANSWER}, "rate answer");
      repeat (2) @(posedge clk_sys_i) #1;
      chk(baud_rate_o === r[(i < 8) ? i : 7], "rate");
      chk(switches === seen + ((i < 8) ? 1 : 0), "rate pulse");
      repeat (20) @(posedge clk_sys_i);
    end
  endtask
  task automatic t_bounds;
    host.xfer(SUB_IMAGE_BOUNDS_REQUEST, COUNT_BOUNDS, 32'h1000, 32'h8000);
    chk(host.ans === {32'h0, 16'h0, RESULT_PASS, SUB_IMAGE_BOUNDS_ANSWER}, "bounds");
    chk({min_addr_o, max_addr_o, bounds_valid_o} === {64'h1000_0000_8000, 1'b1}, "kept");
    host.xfer(SUB_IMAGE_BOUNDS_REQUEST, COUNT_BOUNDS, 32'h9000, 32'h8000);
    chk(host.got === 8 && host.ans === {BOUNDS_RANGE_ERROR, 16'h0, 16'h0006}, "range");
  endtask
  task automatic t_drop;
    host.xfer(SUB_PING_REQUEST, 16'h0001, 32'h1, 32'h0);
    host.xfer(SUB_PING_ANSWER, COUNT_NONE, 32'h1, 32'h0);
    host.xfer(8'h07, COUNT_NONE, 32'h1, 32'h0);
    chk(host.got === 0 && drops === 3, "drop");
  endtask
  task final_report;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    #1 arst_n_i = 1'b1;
    t_ping;
    t_rate;
    t_bounds;
    t_drop;
    final_report;
  end
  initial
  begin
    #100000;
    errors++;
    final_report;
  end
endmodule
